// ---- itv_pkg.sv ----
package itv_pkg;

    // Source count and vector numbering
    localparam int NUM_SRC_DEF = 54;
    localparam int NUM_TRAP = 8;
    localparam logic [5:0] VEC_BASE = 6'h08;
    localparam int CODEC_SRC = 41;

    // Trap levels
    localparam logic [3:0] TRAP_LEVEL_BASE = 4'h8;
    localparam int ADDR_ERR_TRAP = 4;

    // Reset fetch addresses
    localparam logic [23:0] RESET_ADDR = 24'h000000;
    localparam logic [23:0] TARGET_ADDR = 24'h000002;

    // Reset request hold, in clock cycles
    localparam logic [3:0] HOLD_CYCLES = 4'h1;

    // Reset and start-up sequence
    typedef enum logic [3:0] {
        ST_RUN    = 4'b0001,
        ST_HOLD   = 4'b0010,
        ST_JUMP   = 4'b0100,
        ST_TARGET = 4'b1000
    } itv_state_e;

    // Vector offered to the core
    typedef struct packed {
        logic valid;
        logic isTrap;
        logic [5:0] number;
        logic [3:0] level;
    } itv_vec_s;

    // Sticky record of reset causes
    typedef struct packed {
        logic external;
        logic software;
        logic lockout;
        logic brownOut;
        logic illegal;
        logic uninitWreg;
        logic watchdog;
    } itv_cause_s;

endpackage

// ---- itv_pin_sync.sv ----
`timescale 1ns/10ps
`default_nettype none

module itv_pin_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic pinIn,
    output logic pinClean
);

    logic s1, s2, s3;

    // Three stages; a change counts once the last two agree
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1 <= RST_VAL;
            s2 <= RST_VAL;
            s3 <= RST_VAL;
            pinClean <= RST_VAL;
        end else begin
            s1 <= pinIn;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                pinClean <= s3;
            end
        end
    end

endmodule // itv_pin_sync

`default_nettype wire

// ---- itv_vector_ctrl.sv ----
// Behaviour
// - Maskable source n is offered as vector n plus 8; source 0 is vector 8.
// - Reset is handled apart and never produces a vector request.
// - Any reset clears the program counter and starts fetching at address zero.
// - Word zero is a jump; its following word is the start address taken.
// - Watchdog expiry forces a reset.
// - Use of an uninitialised working register as pointer forces a reset.
// - Executing an unused opcode forces an illegal-instruction reset.
// - An unused opcode flushed before execution raises nothing.
// - A brown-out report forces a reset.
// - Several trap conditions at once force a lockout reset.
// - Software reset instruction, external and power-on reset all reach the reset vector.
// - Traps are non-maskable with fixed priority.
// - Vectoring through an invalid entry raises the address error trap.
// - A trap is offered only after the offending instruction completes.
// - Traps use levels 8 to 15, so the level's top bit is set.
// - At level 7 all interrupts are masked yet traps still go.
// - Without the codec interface its slot is never requested.
// - Each source has priority 1 to 7; priority 0 disables it.
// - Only a request above the current processor level interrupts.
// - Equal priorities resolve to the lowest source number.
`timescale 1ns/10ps
`default_nettype none

module itv_vector_ctrl
    import itv_pkg::*;
#(
    parameter int NUM_SRC = NUM_SRC_DEF,
    parameter bit HAS_CODEC = 1'b1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [NUM_SRC-1:0] srcFlag,
    input wire logic [NUM_SRC-1:0] srcEnable,
    input wire logic [NUM_SRC-1:0][2:0] srcPriority,
    input wire logic [3:0] cpuPriorityLevel,
    input wire logic [NUM_TRAP-1:0] trapFlag,
    input wire logic instrDone,
    input wire logic vectorAddrInvalid,
    input wire logic vecTaken,
    input wire logic watchdogExpire,
    input wire logic uninitWregUse,
    input wire logic illegalOpExec,
    input wire logic illegalOpFlushed,
    input wire logic softResetExec,
    input wire logic brownOutPin,
    input wire logic extResetPin_b,
    input wire logic progWordValid,
    input wire logic [23:0] progWord,
    input wire logic causeClear,
    output itv_vec_s vecOut,
    output logic resetReq,
    output logic fetchReq,
    output logic [23:0] fetchAddr,
    output logic pcLoad,
    output logic [23:0] pcValue,
    output itv_cause_s resetCause
);

    itv_state_e state, next_state;
    logic [3:0] holdCnt;
    logic [NUM_TRAP-1:0] trapPend;
    logic trapArmed;
    logic brownOut, extReset_b;

    // Pins from outside the clock domain
    itv_pin_sync #(.RST_VAL(1'b0)) uBorSync (
        .clk(clk),
        .rst_b(rst_b),
        .pinIn(brownOutPin),
        .pinClean(brownOut)
    );

    itv_pin_sync #(.RST_VAL(1'b1)) uExtSync (
        .clk(clk),
        .rst_b(rst_b),
        .pinIn(extResetPin_b),
        .pinClean(extReset_b)
    );

    // Reset cause decode
    wire [NUM_TRAP-1:0] addrErrVec = NUM_TRAP'(vectorAddrInvalid) << ADDR_ERR_TRAP;
    wire [NUM_TRAP-1:0] trapIn = trapFlag | addrErrVec;
    wire illegalEff = illegalOpExec & ~illegalOpFlushed;
    wire lockoutHit = $countones(trapIn) > 1;
    itv_cause_s causeNow;
    assign causeNow.watchdog = watchdogExpire;
    assign causeNow.uninitWreg = uninitWregUse;
    assign causeNow.illegal = illegalEff;
    assign causeNow.brownOut = brownOut;
    assign causeNow.lockout = lockoutHit;
    assign causeNow.software = softResetExec;
    assign causeNow.external = ~extReset_b;
    wire causeAny = |causeNow;
    wire holdDone = (holdCnt >= HOLD_CYCLES - 4'h1);

    // Sequence from reset to the start address
    always_comb begin
        next_state = state;
        unique case (state)
            ST_RUN: begin
                next_state = ST_RUN;
            end
            ST_HOLD: begin
                if (holdDone) begin
                    next_state = ST_JUMP;
                end
            end
            ST_JUMP: begin
                if (progWordValid) begin
                    next_state = ST_TARGET;
                end
            end
            ST_TARGET: begin
                if (progWordValid) begin
                    next_state = ST_RUN;
                end
            end
        endcase
        if (causeAny) begin
            next_state = ST_HOLD;
        end
    end

    // Fetch and program counter drive
    wire leaveHold = (state == ST_HOLD) && holdDone && !causeAny;
    wire gotTarget = (state == ST_TARGET) && progWordValid && !causeAny;
    wire next_fetchReq = (next_state == ST_JUMP) || (next_state == ST_TARGET);
    wire [23:0] next_fetchAddr = (next_state == ST_TARGET) ? TARGET_ADDR : RESET_ADDR;
    wire next_pcLoad = leaveHold || gotTarget;
    wire [23:0] next_pcValue = gotTarget ? progWord : RESET_ADDR;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_HOLD;
            holdCnt <= 4'h0;
        end else begin
            state <= next_state;
            holdCnt <= (state == ST_HOLD && !causeAny) ? holdCnt + 4'h1 : 4'h0;
        end
    end

    // Registered sequence outputs
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            resetReq <= 1'b1;
            fetchReq <= 1'b0;
            fetchAddr <= RESET_ADDR;
            pcLoad <= 1'b0;
            pcValue <= RESET_ADDR;
        end else begin
            resetReq <= (next_state == ST_HOLD);
            fetchReq <= next_fetchReq;
            fetchAddr <= next_fetchAddr;
            pcLoad <= next_pcLoad;
            pcValue <= next_pcValue;
        end
    end

    // Sticky causes; a new cause wins over clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            resetCause <= '0;
        end else begin
            resetCause <= (causeClear ? '0 : resetCause) | causeNow;
        end
    end

    // Maskable source eligibility
    logic [NUM_SRC-1:0] srcEligible;
    always_comb begin
        for (int i = 0; i < NUM_SRC; i++) begin
            srcEligible[i] = srcFlag[i] & srcEnable[i] & (srcPriority[i] != 3'h0);
            if (i == CODEC_SRC && !HAS_CODEC) begin
                srcEligible[i] = 1'b0;
            end
        end
    end

    // Highest priority, lowest number wins a tie
    logic [2:0] bestPrio;
    logic [5:0] bestIdx;
    always_comb begin
        bestPrio = 3'h0;
        bestIdx = 6'h00;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (srcEligible[i] && srcPriority[i] >= bestPrio) begin
                bestPrio = srcPriority[i];
                bestIdx = 6'(i);
            end
        end
    end

    // Highest pending trap
    logic [2:0] bestTrap;
    always_comb begin
        bestTrap = 3'h0;
        for (int i = 0; i < NUM_TRAP; i++) begin
            if (trapPend[i]) begin
                bestTrap = 3'(i);
            end
        end
    end

    // Level comparison against the core
    wire srcAny = |srcEligible;
    wire [3:0] trapLevel = TRAP_LEVEL_BASE | {1'b0, bestTrap};
    wire takeTrap = (|trapPend) && trapArmed && (trapLevel > cpuPriorityLevel);
    wire takeIrq = srcAny && ({1'b0, bestPrio} > cpuPriorityLevel);
    wire running = (state == ST_RUN);

    itv_vec_s next_vec;
    assign next_vec.valid = running && (takeTrap || takeIrq);
    assign next_vec.isTrap = takeTrap;
    assign next_vec.number = takeTrap ? {3'h0, bestTrap} : bestIdx + VEC_BASE;
    assign next_vec.level = takeTrap ? trapLevel : {1'b0, bestPrio};

    // Taken trap clears its bit unless it rearrives
    wire [NUM_TRAP-1:0] trapTakenBit = (vecTaken && vecOut.valid && vecOut.isTrap) ?
        (NUM_TRAP'(1) << vecOut.number[2:0]) : '0;
    wire [NUM_TRAP-1:0] next_trapPend = (trapPend & ~trapTakenBit) | trapIn;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            trapPend <= '0;
            trapArmed <= 1'b0;
            vecOut <= '0;
        end else begin
            trapPend <= running ? next_trapPend : '0;
            trapArmed <= (next_trapPend != '0) && (trapArmed || instrDone);
            vecOut <= next_vec;
        end
    end

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_vec_number_map: assert property (next_vec.valid && !next_vec.isTrap |=>
        vecOut.number == $past(bestIdx) + VEC_BASE)
        else $error("maskable vector number wrong");
    a_no_vec_reset: assert property (!running |=> !vecOut.valid)
        else $error("vector offered during reset");
    a_pc_clear: assert property (leaveHold |=> pcLoad && pcValue == RESET_ADDR && fetchAddr == RESET_ADDR)
        else $error("program counter not cleared");
    a_jump_target: assert property (gotTarget |=> pcLoad && pcValue == $past(progWord) && state == ST_RUN)
        else $error("jump target not loaded");
    a_cause_reset: assert property (watchdogExpire || uninitWregUse || softResetExec |=>
        resetReq && state == ST_HOLD)
        else $error("cause did not reset");
    a_illegal_exec: assert property (illegalOpExec && !illegalOpFlushed |=> resetCause.illegal)
        else $error("illegal opcode not trapped");
    a_illegal_flush: assert property (illegalOpExec && illegalOpFlushed && !causeClear |=>
        resetCause.illegal == $past(resetCause.illegal))
        else $error("flushed opcode trapped");
    a_lockout_hit: assert property ($countones(trapFlag) > 1 |=> resetCause.lockout && resetReq)
        else $error("multiple traps no lockout");
    a_addr_err: assert property (vectorAddrInvalid && running |=> trapPend[ADDR_ERR_TRAP])
        else $error("address error trap missing");
    a_trap_after_done: assert property (next_vec.isTrap && next_vec.valid |-> trapArmed)
        else $error("trap before instruction done");
    a_trap_msb: assert property (vecOut.valid && vecOut.isTrap |-> vecOut.level[3])
        else $error("trap level msb clear");
    a_level_gate: assert property (vecOut.valid |-> vecOut.level > $past(cpuPriorityLevel))
        else $error("request not above level");
    a_irq_msb: assert property (vecOut.valid && !vecOut.isTrap |-> !vecOut.level[3] && vecOut.level != 4'h0)
        else $error("maskable level out of range");
    a_hold_before: assert property ($rose(pcLoad) && pcValue == RESET_ADDR |-> $past(resetReq))
        else $error("reload without held request");
    a_reset_hold: assert property ($fell(resetReq) |-> !$past(causeAny))
        else $error("request dropped while cause stands");

    // Arbitration cross-check: no eligible rival outranks the winner
    logic rivalSeen;
    always_comb begin
        rivalSeen = 1'b0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (srcEligible[i] && srcPriority[i] > bestPrio) begin
                rivalSeen = 1'b1;
            end
            if (srcEligible[i] && srcPriority[i] == bestPrio && 6'(i) < bestIdx) begin
                rivalSeen = 1'b1;
            end
        end
    end

    // Selection checks
    a_arb_rival: assert property (srcAny |-> !rivalSeen)
        else $error("outranked source offered");
    a_arb_eligible: assert property (srcAny |-> srcEligible[bestIdx])
        else $error("ineligible source offered");
    a_zero_prio: assert property (srcAny |-> srcPriority[bestIdx] != 3'h0)
        else $error("disabled priority offered");
    a_codec_reserved: assert property (!HAS_CODEC && srcAny |-> bestIdx != 6'(CODEC_SRC))
        else $error("reserved codec slot offered");
    a_irq_base: assert property (vecOut.valid && !vecOut.isTrap |-> vecOut.number >= VEC_BASE)
        else $error("maskable vector below base");
    a_level_seven: assert property (cpuPriorityLevel == 4'h7 && next_vec.valid |-> next_vec.isTrap)
        else $error("interrupt taken at level seven");

    // Trap checks
    a_trap_highest: assert property ((|trapPend) |-> (trapPend >> bestTrap) == NUM_TRAP'(1))
        else $error("lower trap chosen first");
    a_trap_level: assert property (vecOut.valid && vecOut.isTrap |->
        vecOut.level == TRAP_LEVEL_BASE + 4'(vecOut.number))
        else $error("trap level not fixed");
    a_trap_needs_done: assert property ($rose(trapArmed) |-> $past(instrDone))
        else $error("trap armed without completion");
    a_trap_clear: assert property (vecTaken && vecOut.valid && vecOut.isTrap && !trapIn[vecOut.number[2:0]] |=>
        !trapPend[$past(vecOut.number[2:0])])
        else $error("taken trap still pending");
    a_addr_lockout: assert property (vectorAddrInvalid && trapFlag != '0 && !trapFlag[ADDR_ERR_TRAP] |=>
        resetCause.lockout)
        else $error("address error lockout missing");

    // Reset cause checks
    a_watchdog_cause: assert property (watchdogExpire |=> resetCause.watchdog)
        else $error("watchdog cause not recorded");
    a_uninit_cause: assert property (uninitWregUse |=> resetCause.uninitWreg)
        else $error("pointer cause not recorded");
    a_brownout_reset: assert property (brownOut |=> resetReq && resetCause.brownOut)
        else $error("brown-out did not reset");
    a_soft_cause: assert property (softResetExec |=> resetCause.software)
        else $error("software cause not recorded");
    a_extern_reset: assert property (!extReset_b |=> resetReq && resetCause.external)
        else $error("external reset not taken");

    // Boot fetch checks
    a_fetch_start: assert property ($rose(fetchReq) |-> fetchAddr == RESET_ADDR)
        else $error("first fetch not at zero");
    a_fetch_target: assert property (gotTarget |-> fetchAddr == TARGET_ADDR)
        else $error("target word from wrong address");

    c_irq_offer: cover property (vecOut.valid && !vecOut.isTrap);
    c_trap_offer: cover property (vecOut.valid && vecOut.isTrap);
    c_boot: cover property (gotTarget);
    c_lockout: cover property (lockoutHit);
    c_tie: cover property (srcAny && $countones(srcEligible) > 1);

endmodule // itv_vector_ctrl

`default_nettype wire

// ---- itv_core_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module itv_core_model
    import itv_pkg::*;
#(
    parameter logic [23:0] START_ADDR = 24'h000400,
    parameter logic [23:0] JUMP_WORD = 24'h040000
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [1:0] delay,
    input wire logic fetchReq,
    input wire logic [23:0] fetchAddr,
    input wire itv_vec_s vecOut,
    output logic progWordValid,
    output logic [23:0] progWord,
    output logic vecTaken
);
    logic [1:0] waitCnt;
    logic served;
    logic [23:0] servedAddr;

    // Program memory answers word fetches; between answers the bus inverts every bit of its word each cycle
    always @(negedge clk or negedge rst_b) begin
        if (!rst_b) begin
            waitCnt <= 2'h0;
            served <= 1'b0;
            servedAddr <= 24'h000000;
            progWordValid <= 1'b0;
            progWord <= 24'h000000;
            vecTaken <= 1'b0;
        end else begin
            progWordValid <= 1'b0;
            progWord <= ~progWord;
            vecTaken <= vecOut.valid && vecOut.isTrap && !vecTaken;
            if (!fetchReq) begin
                waitCnt <= 2'h0;
                served <= 1'b0;
            end else if (!(served && servedAddr == fetchAddr) && !progWordValid) begin
                if (waitCnt < delay) begin
                    waitCnt <= waitCnt + 2'h1;
                end else begin
                    waitCnt <= 2'h0;
                    served <= 1'b1;
                    servedAddr <= fetchAddr;
                    progWordValid <= 1'b1;
                    progWord <= (fetchAddr == RESET_ADDR) ? JUMP_WORD : START_ADDR;
                end
            end
        end
    end
endmodule // itv_core_model

`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin samplesChecked++; if ((got) !== (ex)) begin mismatches++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end

module testbench;
    import itv_pkg::*;
    localparam logic [23:0] START = 24'h000400;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [NUM_SRC_DEF-1:0] srcFlag = '0;
    logic [NUM_SRC_DEF-1:0] srcEnable = '0;
    logic [NUM_SRC_DEF-1:0][2:0] srcPriority = '0;
    logic [3:0] cpuLevel = 4'h0;
    logic [NUM_TRAP-1:0] trapFlag = '0;
    logic instrDone = 1'b0, addrBad = 1'b0, watchdogExpire = 1'b0, uninitWregUse = 1'b0;
    logic illegalOpExec = 1'b0, illegalOpFlushed = 1'b0, softResetExec = 1'b0;
    logic brownOutPin = 1'b0, extResetPin_b = 1'b1, causeClear = 1'b0;
    logic [1:0] delay = 2'h0;
    logic progWordValid, fetchReq, pcLoad, resetReq, vecTaken;
    logic [23:0] progWord, fetchAddr, pcValue, expPc;
    itv_vec_s vecOut, prevVec, expVec;
    itv_cause_s resetCause;
    int mismatches = 0, samplesChecked = 0, cycles = 0;
    logic [31:0] rng = 32'd92;
    logic [23:0] pcQ[$];
    itv_vec_s vecQ[$];

    itv_vector_ctrl #(.NUM_SRC(NUM_SRC_DEF), .HAS_CODEC(1'b1)) itv_vector_ctrl_inst (.clk(clk), .rst_b(rst_b),
        .srcFlag(srcFlag), .srcEnable(srcEnable), .srcPriority(srcPriority), .cpuPriorityLevel(cpuLevel),
        .trapFlag(trapFlag), .instrDone(instrDone), .vectorAddrInvalid(addrBad), .vecTaken(vecTaken),
        .watchdogExpire(watchdogExpire), .uninitWregUse(uninitWregUse), .illegalOpExec(illegalOpExec),
        .illegalOpFlushed(illegalOpFlushed), .softResetExec(softResetExec), .brownOutPin(brownOutPin),
        .extResetPin_b(extResetPin_b), .progWordValid(progWordValid), .progWord(progWord),
        .causeClear(causeClear), .vecOut(vecOut), .resetReq(resetReq), .fetchReq(fetchReq),
        .fetchAddr(fetchAddr), .pcLoad(pcLoad), .pcValue(pcValue), .resetCause(resetCause));
    itv_core_model #(.START_ADDR(START)) itv_core_model_inst (.clk(clk), .rst_b(rst_b), .delay(delay),
        .fetchReq(fetchReq), .fetchAddr(fetchAddr), .vecOut(vecOut), .progWordValid(progWordValid),
        .progWord(progWord), .vecTaken(vecTaken));

    // Clock and hang guard
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            end_of_test();
        end
    end

    // Result watcher pairs each new output with the oldest note
    always @(posedge clk) begin
        #1;
        if (pcLoad === 1'b1) begin
            expPc = (pcQ.size() > 0) ? pcQ.pop_front() : 24'hffffff;
            `CHK("pcValue", expPc, pcValue)
            `CHK("bootFetch", expPc == RESET_ADDR, fetchReq)
            if (fetchReq === 1'b1) `CHK("fetchAddr", RESET_ADDR, fetchAddr)
        end
        if (progWordValid === 1'b1 && fetchAddr !== RESET_ADDR) `CHK("targetAddr", TARGET_ADDR, fetchAddr)
        if (vecOut.valid === 1'b1 && vecOut !== prevVec) begin
            expVec = (vecQ.size() > 0) ? vecQ.pop_front() : '0;
            `CHK("vecOut", expVec, vecOut)
        end
        if (resetReq === 1'b1) `CHK("vecDuringReset", 1'b0, vecOut.valid)
        prevVec = vecOut;
    end

    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Waits for the fetch of both start words to finish
    task automatic boot_wait();
        int seen;
        seen = 0;
        for (int t = 0; t < 300; t++) begin
            tick(1);
            if (fetchReq === 1'b1) seen = 1;
            else if (seen == 1) break;
        end
    endtask

    task automatic mask(input int a, input int b, input logic [2:0] p, input logic [3:0] lvl, input logic hit);
        srcPriority[a] = p;
        srcPriority[b] = p;
        srcEnable[a] = 1'b1;
        srcEnable[b] = 1'b1;
        cpuLevel = lvl;
        if (hit) vecQ.push_back(itv_vec_s'{1'b1, 1'b0, VEC_BASE + 6'(a), {1'b0, p}});
        srcFlag[a] = 1'b1;
        srcFlag[b] = 1'b1;
        tick(3);
        if (!hit) `CHK("vecMasked", 1'b0, vecOut.valid)
        srcFlag = '0;
        tick(3);
    endtask

    task automatic trap(input int i, input logic viaAddr);
        vecQ.push_back(itv_vec_s'{1'b1, 1'b1, 6'(i), TRAP_LEVEL_BASE + 4'(i)});
        if (viaAddr) addrBad = 1'b1;
        else trapFlag = 8'h01 << i;
        tick(1);
        addrBad = 1'b0;
        trapFlag = '0;
        tick(3);
        `CHK("trapEarly", 1'b0, vecOut.valid)
        instrDone = 1'b1;
        tick(1);
        instrDone = 1'b0;
        tick(6);
        `CHK("trapTaken", 1'b0, vecOut.valid)
    endtask

    task automatic cause(input int k);
        pcQ.push_back(RESET_ADDR);
        pcQ.push_back(START);
        delay = 2'(k);
        case (k)
            0: watchdogExpire = 1'b1;
            1: uninitWregUse = 1'b1;
            2: illegalOpExec = 1'b1;
            3: brownOutPin = 1'b1;
            4: trapFlag = 8'h11;
            5: softResetExec = 1'b1;
            default: extResetPin_b = 1'b0;
        endcase
        tick((k == 3 || k == 6) ? 5 : 1);
        {watchdogExpire, uninitWregUse, illegalOpExec, brownOutPin, softResetExec} = '0;
        trapFlag = '0;
        extResetPin_b = 1'b1;
        boot_wait();
        `CHK("resetCause", 7'h01 << k, resetCause)
        causeClear = 1'b1;
        tick(1);
        causeClear = 1'b0;
        tick(1);
        `CHK("causeCleared", 7'h00, resetCause)
    endtask

    task automatic end_of_test();
        if (pcQ.size() != 0 || vecQ.size() != 0) mismatches++;
        $display("Comparisons %0d, mismatches %0d", samplesChecked, mismatches);
        if (mismatches == 0 && samplesChecked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Main sequence
    initial begin
        int a;
        int b;
        logic [31:0] r;
        pcQ.push_back(RESET_ADDR);
        pcQ.push_back(START);
        tick(10);
        rst_b = 1'b1;
        boot_wait();
        for (int n = 0; n < 12; n++) begin
            r = xs();
            for (int j = 0; j < NUM_SRC_DEF; j++) srcPriority[j] = 3'(r >> (j % 29));
            srcEnable = {r[21:0], r};
            a = int'(r % 54);
            b = a + int'(r[15:8] % (54 - a));
            mask(a, b, 3'(r[18:16] % 7 + 1), 4'(r[22:20] % (r[18:16] % 7 + 1)), 1'b1);
        end
        mask(0, 0, 3'h1, 4'h0, 1'b1);
        mask(53, 53, 3'h7, 4'h6, 1'b1);
        mask(5, 5, 3'h0, 4'h0, 1'b0);
        mask(5, 5, 3'h4, 4'h4, 1'b0);
        mask(5, 5, 3'h7, 4'h7, 1'b0);
        for (int i = 0; i < NUM_TRAP; i++) trap(i, 1'b0);
        trap(ADDR_ERR_TRAP, 1'b1);
        illegalOpExec = 1'b1;
        illegalOpFlushed = 1'b1;
        tick(1);
        illegalOpExec = 1'b0;
        illegalOpFlushed = 1'b0;
        tick(4);
        `CHK("flushedOpReset", 1'b0, resetReq)
        for (int k = 0; k < 7; k++) cause(k);
        end_of_test();
    end
endmodule // testbench

`default_nettype wire
